// file: hw/motor_fault_and_power_mode_ctrl.v
/*
 * motor_fault_and_power_mode_ctrl: protection flags, speed source
 * selection, duty peak shaping and sleep/standby control.
 * assumes comparator and speed pin inputs are asynchronous; the speed
 * level, clamp and waveform inputs come from logic on sys_clk_in.
 * registers are reached through the serial interface's register port.
 */
`timescale 1ns/10ps
`include "motor_fault_map.vh"
module motor_fault_and_power_mode_ctrl
#(
    parameter SLEEP_VARIANT = 1,
    parameter TW            = 32,
    parameter WIN_W         = 20,
    parameter LOCK_OFF_CYC  = `T_LOCK_OFF_US * `CLK_MHZ,
    parameter EN_SB_ANA_CYC = `T_EN_SB_ANA_US * `CLK_MHZ,
    parameter EN_SL_ANA_CYC = `T_EN_SL_ANA_US * `CLK_MHZ,
    parameter EX_SB_ANA_CYC = `T_EX_SB_ANA_US * `CLK_MHZ,
    parameter EX_SL_ANA_CYC = `T_EX_SL_ANA_US * `CLK_MHZ,
    parameter EN_SL_PWM_CYC = `T_EN_SL_PWM_US * `CLK_MHZ,
    parameter EX_SB_PWM_CYC = `T_EX_SB_PWM_US * `CLK_MHZ,
    parameter EX_SL_PWM_CYC = `T_EX_SL_PWM_US * `CLK_MHZ,
    parameter EN_SB_I2C_CYC = `T_EN_SB_I2C_US * `CLK_MHZ,
    parameter EX_SB_I2C_CYC = `T_EX_SB_I2C_US * `CLK_MHZ
)
(
    input  wire        sys_clk_in,
    input  wire        rst_b_in,
    input  wire        ce_in,
    input  wire        temp_over_sdn_in,
    input  wire        temp_below_rec_in,
    input  wire        temp_warn_in,
    input  wire        vcc_below_fall_in,
    input  wire        vcc_above_rise_in,
    input  wire        buck_uv_in,
    input  wire        cp_uv_in,
    input  wire        ldo_uv_in,
    input  wire        oc_detect_in,
    input  wire        vcc_above_ov_in,
    input  wire        vcc_below_ov_exit_in,
    input  wire [5:0]  lock_detect_in,
    input  wire        speed_pin_in,
    input  wire [8:0]  speed_level_in,
    input  wire [8:0]  clamp_limit_in,
    input  wire [7:0]  wave_a_in,
    input  wire [7:0]  wave_b_in,
    input  wire [7:0]  wave_c_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    output reg  [15:0] reg_rdata_out,
    output reg  [8:0]  output_duty_peak_out,
    output reg  [8:0]  phase_a_duty_out,
    output reg  [8:0]  phase_b_duty_out,
    output reg  [8:0]  phase_c_duty_out,
    output reg         drive_en_out,
    output reg         outputs_hiz_out,
    output reg         buck_en_out,
    output reg         serial_en_out,
    output reg  [1:0]  power_state_out
);
    localparam NSYNC = 18;

    reg [NSYNC-1:0] sync1_r;
    reg [NSYNC-1:0] sync2_r;
    reg             tsd_r;
    reg             uvlo_r;
    reg             ov_r;
    reg             oc_flag_r;
    reg             off_r;
    reg             hiz_r;
    reg  [TW-1:0]   off_cnt_r;
    reg  [5:0]      lock_type_r;
    reg  [15:0]     speed_reg_r;
    reg  [15:0]     ctrl_r;
    reg  [1:0]      pstate_r;
    reg  [WIN_W-1:0] win_r;
    reg  [WIN_W:0]  high_cnt_r;
    reg  [8:0]      pulse_duty_r;
    reg  [8:0]      cmd_nxt;
    reg  [8:0]      lim_nxt;
    reg  [8:0]      peak_nxt;
    reg  [8:0]      pulse_cmd;
    reg             en_cond;
    reg             ex_cond;
    reg  [TW-1:0]   en_lim;
    reg  [TW-1:0]   ex_lim;
    reg  [1:0]      pstate_nxt;
    reg  [7:0]      wmin;

    wire s_tsd_over  = sync2_r[0];
    wire s_tsd_rec   = sync2_r[1];
    wire s_warn      = sync2_r[2];
    wire s_uv_fall   = sync2_r[3];
    wire s_uv_rise   = sync2_r[4];
    wire s_sub_uv    = sync2_r[5] | sync2_r[6] | sync2_r[7];
    wire s_oc        = sync2_r[8];
    wire s_ov        = sync2_r[9];
    wire s_ov_exit   = sync2_r[10];
    wire s_pin       = sync2_r[11];
    wire [5:0] s_lock = sync2_r[17:12];
    wire s_locked    = |s_lock;

    wire [1:0] src    = ctrl_r[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB];
    wire [1:0] minsel = ctrl_r[`CTRL_MIN_LSB+1:`CTRL_MIN_LSB];
    wire [8:0] spd_val = speed_reg_r[`SPEED_MSB:0];
    wire host_a   = speed_reg_r[`BIT_HOST_CMD_A];
    wire asleep   = (pstate_r == `ST_SLEEP);
    wire reg_ok   = !asleep;
    wire wr_speed = reg_wr_in && reg_ok && (reg_addr_in == `ADDR_SPEED_CMD);
    wire wr_ctrl  = reg_wr_in && reg_ok && (reg_addr_in == `ADDR_CTRL);
    wire rd_fault = reg_rd_in && reg_ok && (reg_addr_in == `ADDR_FAULT_STATUS);
    wire [WIN_W+8:0] hc_ext = {high_cnt_r[WIN_W-1:0], 9'h000};
    wire en_done;
    wire ex_done;
    wire drive_ok;

    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sync1_r <= {NSYNC{1'b0}};
            sync2_r <= {NSYNC{1'b0}};
        end
        else if (ce_in)
        begin
            sync1_r <= {lock_detect_in, speed_pin_in, vcc_below_ov_exit_in,
                        vcc_above_ov_in, oc_detect_in, ldo_uv_in, cp_uv_in,
                        buck_uv_in, vcc_above_rise_in, vcc_below_fall_in,
                        temp_warn_in, temp_below_rec_in, temp_over_sdn_in};
            sync2_r <= sync1_r;
        end
    end

    // hysteretic protection latches; lockout asserted from reset
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tsd_r  <= 1'b0;
            uvlo_r <= 1'b1;
            ov_r   <= 1'b0;
        end
        else if (ce_in)
        begin
            if (s_tsd_over)
                tsd_r <= 1'b1;
            else if (s_tsd_rec)
                tsd_r <= 1'b0;
            if (s_uv_fall || s_sub_uv)
                uvlo_r <= 1'b1;
            else if (s_uv_rise)
                uvlo_r <= 1'b0;
            if (s_ov)
                ov_r <= 1'b1;
            else if (s_ov_exit)
                ov_r <= 1'b0;
        end
    end

    // lock-off cycle shared by overcurrent and rotor lock
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            off_r       <= 1'b0;
            hiz_r       <= 1'b0;
            off_cnt_r   <= {TW{1'b0}};
            lock_type_r <= 6'h00;
            oc_flag_r   <= 1'b0;
        end
        else if (ce_in)
        begin
            if (s_oc)
                oc_flag_r <= 1'b1;
            else if (rd_fault)
                oc_flag_r <= 1'b0;
            if (!off_r && (s_oc || s_locked))
            begin
                off_r       <= 1'b1;
                hiz_r       <= s_oc;
                off_cnt_r   <= LOCK_OFF_CYC;
                lock_type_r <= s_lock;
            end
            else if (off_r)
            begin
                lock_type_r <= lock_type_r | s_lock;
                hiz_r       <= hiz_r | s_oc;
                if (off_cnt_r <= {{(TW-1){1'b0}}, 1'b1})
                begin
                    off_r <= 1'b0;
                    hiz_r <= 1'b0;
                    if (!s_locked)
                        lock_type_r <= 6'h00;
                end
                else
                    off_cnt_r <= off_cnt_r - {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end

    // serial registers; the speed register is volatile across sleep
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            speed_reg_r <= `SPEED_CMD_RESET;
            ctrl_r      <= `CTRL_RESET;
        end
        else if (ce_in)
        begin
            if (asleep)
                speed_reg_r <= `SPEED_CMD_RESET;
            else if (wr_speed)
                speed_reg_r <= reg_wdata_in;
            if (wr_ctrl)
                ctrl_r <= reg_wdata_in;
        end
    end

    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= 16'h0000;
        else if (ce_in && reg_rd_in)
        begin
            reg_rdata_out <= 16'h0000;
            if (reg_ok)
                case (reg_addr_in)
                    `ADDR_FAULT_STATUS:
                    begin
                        reg_rdata_out[`BIT_OVER_TEMP] <= tsd_r;
                        reg_rdata_out[`BIT_TEMP_WARN] <= s_warn;
                        reg_rdata_out[`BIT_UVLO]      <= uvlo_r;
                        reg_rdata_out[`BIT_OVER_VOLT] <= ov_r;
                        reg_rdata_out[`BIT_OVER_CURR] <= oc_flag_r;
                        reg_rdata_out[`LOCK_LSB+`LOCK_W-1:`LOCK_LSB]
                            <= lock_type_r;
                    end
                    `ADDR_SPEED_CMD: reg_rdata_out <= speed_reg_r;
                    `ADDR_CTRL:      reg_rdata_out <= ctrl_r;
                    default:         reg_rdata_out <= 16'h0000;
                endcase
        end
    end

    // pulse duty: high time over a fixed window of 2^WIN_W cycles
    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            win_r        <= {WIN_W{1'b0}};
            high_cnt_r   <= {(WIN_W+1){1'b0}};
            pulse_duty_r <= 9'h000;
        end
        else if (ce_in)
        begin
            win_r <= win_r + {{(WIN_W-1){1'b0}}, 1'b1};
            if (&win_r)
            begin
                high_cnt_r <= {(WIN_W+1){1'b0}};
                if (high_cnt_r[WIN_W])
                    pulse_duty_r <= `DUTY_FULL;
                else
                    pulse_duty_r <= hc_ext[WIN_W+8:WIN_W];
            end
            else if (s_pin)
                high_cnt_r <= high_cnt_r + {{WIN_W{1'b0}}, 1'b1};
        end
    end

    always @*
    begin
        case (minsel)
            2'h1:    lim_nxt = `MIN_DUTY_1;
            2'h2:    lim_nxt = `MIN_DUTY_2;
            2'h3:    lim_nxt = `MIN_DUTY_3;
            default: lim_nxt = 9'h000;
        endcase
        pulse_cmd = (pulse_duty_r < lim_nxt) ? lim_nxt : pulse_duty_r;
        case (src)
            `SRC_ANALOG: cmd_nxt = speed_level_in;
            `SRC_PULSE:  cmd_nxt = pulse_cmd;
            `SRC_SERIAL: cmd_nxt = spd_val;
            default:     cmd_nxt = 9'h000;
        endcase
        peak_nxt = (clamp_limit_in < cmd_nxt) ? clamp_limit_in
                                              : cmd_nxt;
    end

    // sleep/standby entry and exit conditions per command source
    always @*
    begin
        en_cond = 1'b0;
        ex_cond = 1'b0;
        en_lim  = EN_SB_ANA_CYC;
        ex_lim  = EX_SB_ANA_CYC;
        case (src)
            `SRC_ANALOG:
            begin
                en_cond = SLEEP_VARIANT ? (speed_level_in < `LVL_EN_SL)
                                        : (speed_level_in < `LVL_EN_SB);
                ex_cond = SLEEP_VARIANT ? (speed_level_in > `LVL_EX_SL)
                                        : (speed_level_in > `LVL_EX_SB);
                en_lim  = SLEEP_VARIANT ? EN_SL_ANA_CYC : EN_SB_ANA_CYC;
                ex_lim  = SLEEP_VARIANT ? EX_SL_ANA_CYC : EX_SB_ANA_CYC;
            end
            `SRC_PULSE:
            begin
                en_cond = !s_pin;
                ex_cond = s_pin;
                en_lim  = EN_SL_PWM_CYC;
                ex_lim  = SLEEP_VARIANT ? EX_SL_PWM_CYC : EX_SB_PWM_CYC;
            end
            `SRC_SERIAL:
            begin
                if (SLEEP_VARIANT)
                begin
                    en_cond = host_a && (spd_val == 9'h000) && !s_pin;
                    ex_cond = s_pin;
                    en_lim  = EN_SL_PWM_CYC;
                    ex_lim  = EX_SL_PWM_CYC;
                end
                else
                begin
                    en_cond = (spd_val == 9'h000);
                    ex_cond = (spd_val != 9'h000);
                    en_lim  = EN_SB_I2C_CYC;
                    ex_lim  = EX_SB_I2C_CYC;
                end
            end
            default:
            begin
                en_cond = 1'b0;
                ex_cond = 1'b0;
            end
        endcase
    end

    hold_qualifier #(.TW(TW)) u_enter_q
    (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .ce_in      (ce_in),
        .cond_in    (en_cond && (pstate_r == `ST_ACTIVE)),
        .limit_in   (en_lim),
        .done_out   (en_done)
    );

    hold_qualifier #(.TW(TW)) u_exit_q
    (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .ce_in      (ce_in),
        .cond_in    (ex_cond && (pstate_r != `ST_ACTIVE)),
        .limit_in   (ex_lim),
        .done_out   (ex_done)
    );

    always @*
    begin
        pstate_nxt = pstate_r;
        case (pstate_r)
            `ST_ACTIVE:
                if (en_done)
                    pstate_nxt = SLEEP_VARIANT ? `ST_SLEEP : `ST_STANDBY;
            `ST_STANDBY:
                if (ex_done)
                    pstate_nxt = `ST_ACTIVE;
            `ST_SLEEP:
                if (ex_done)
                    pstate_nxt = `ST_ACTIVE;
            default:
                pstate_nxt = `ST_ACTIVE;
        endcase
    end

    assign drive_ok = !tsd_r && !uvlo_r && !ov_r && !off_r
                   && (pstate_nxt == `ST_ACTIVE);

    always @*
    begin
        wmin = wave_a_in;
        if (wave_b_in < wmin)
            wmin = wave_b_in;
        if (wave_c_in < wmin)
            wmin = wave_c_in;
    end

    function [8:0] phase_duty;
        input [7:0] w;
        input [7:0] m;
        input [8:0] pk;
        reg   [7:0] d;
        reg   [8:0] d9;
        reg   [17:0] p;
        begin
            d  = w - m;
            d9 = {1'b0, d} + {8'h00, (d == 8'hff)};
            p  = d9 * pk;
            phase_duty = p[16:8];
        end
    endfunction

    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pstate_r             <= `ST_ACTIVE;
            output_duty_peak_out <= 9'h000;
            phase_a_duty_out     <= 9'h000;
            phase_b_duty_out     <= 9'h000;
            phase_c_duty_out     <= 9'h000;
            drive_en_out         <= 1'b0;
            outputs_hiz_out      <= 1'b0;
            buck_en_out          <= 1'b1;
            serial_en_out        <= 1'b1;
            power_state_out      <= `ST_ACTIVE;
        end
        else if (ce_in)
        begin
            pstate_r             <= pstate_nxt;
            output_duty_peak_out <= peak_nxt;
            drive_en_out         <= drive_ok;
            outputs_hiz_out      <= hiz_r;
            buck_en_out          <= (pstate_nxt != `ST_SLEEP);
            serial_en_out        <= (pstate_nxt != `ST_SLEEP);
            power_state_out      <= pstate_nxt;
            if (drive_ok && !hiz_r)
            begin
                phase_a_duty_out <= phase_duty(wave_a_in, wmin, peak_nxt);
                phase_b_duty_out <= phase_duty(wave_b_in, wmin, peak_nxt);
                phase_c_duty_out <= phase_duty(wave_c_in, wmin, peak_nxt);
            end
            else
            begin
                phase_a_duty_out <= 9'h000;
                phase_b_duty_out <= 9'h000;
                phase_c_duty_out <= 9'h000;
            end
        end
    end
endmodule // motor_fault_and_power_mode_ctrl

// file: hw/motor_fault_map.vh
/*
 * register map, field positions and timing constants of the motor fault
 * and power-mode controller.
 * assumes a 100 MHz system clock; comparator thresholds are digital
 * codes on the 9-bit speed scale (0x1ff is full scale).
 */
// What this block does
// - thermal shutdown halts drive, hysteretic recovery
// - over-temperature flag bit 15 during shutdown
// - temperature warning flag bit 14, independent
// - supply lockout with falling/rising hysteresis
// - buck, charge pump, LDO lockouts too
// - overcurrent: outputs high-z until lock-off timer
// - overcurrent flag bit 11 set on event
// - rotor lock stops drive immediately
// - retry after lock-off time, repeat while locked
// - status shows which lock type triggered
// - one speed source sets output duty peak
// - two-bit minimum duty limit on pulse input
// - external limiters may clamp duty below command
// - one phase grounded, two phases modulated
// - duty peak scales amplitude to supply
// - overvoltage stops drive, hysteretic exit
// - sleep or standby stops driving
// - sleep disables regulator, serial, volatile registers
// - standby keeps regulator, registers, serial port
// - analog mode: level thresholds with entry/exit times
// - pulse mode: pin low enters, high exits
// - serial mode: zero value enters, non-zero exits (standby); sleep: bit 15 set with zero value and pin low enters, pin high exits
`ifndef MOTOR_FAULT_MAP_VH
`define MOTOR_FAULT_MAP_VH

`define CLK_MHZ           100
`define ADDR_FAULT_STATUS 8'h00
`define ADDR_SPEED_CMD    8'h30
`define ADDR_CTRL         8'h3c

`define BIT_OVER_TEMP     15
`define BIT_TEMP_WARN     14
`define BIT_UVLO          13
`define BIT_OVER_VOLT     12
`define BIT_OVER_CURR     11
`define LOCK_LSB          0
`define LOCK_W            6

`define BIT_HOST_CMD_A    15
`define SPEED_MSB         8
`define CTRL_SRC_LSB      0
`define CTRL_MIN_LSB      2

`define SPEED_CMD_RESET   16'h0000
`define CTRL_RESET        16'h0000

`define SRC_ANALOG        2'h0
`define SRC_PULSE         2'h1
`define SRC_SERIAL        2'h2

`define MIN_DUTY_1        9'h033
`define MIN_DUTY_2        9'h04d
`define MIN_DUTY_3        9'h066
`define DUTY_FULL         9'h1ff

`define LVL_EN_SB         9'h010
`define LVL_EN_SL         9'h010
`define LVL_EX_SB         9'h020
`define LVL_EX_SL         9'h040

`define T_LOCK_OFF_US     5000000
`define T_EN_SB_ANA_US    1000
`define T_EN_SL_ANA_US    1000
`define T_EX_SB_ANA_US    100
`define T_EX_SL_ANA_US    1000
`define T_EN_SL_PWM_US    1000
`define T_EX_SB_PWM_US    100
`define T_EX_SL_PWM_US    1000
`define T_EN_SB_I2C_US    1000
`define T_EX_SB_I2C_US    100

`define ST_ACTIVE         2'h0
`define ST_STANDBY        2'h1
`define ST_SLEEP          2'h2

`endif

// file: hw/hold_qualifier.v
/*
 * hold_qualifier: reports a condition that has held for a set count.
 * assumes cond_in is already synchronous to sys_clk_in.
 */
`timescale 1ns/10ps
module hold_qualifier
#(
    parameter TW = 32
)
(
    input  wire          sys_clk_in,
    input  wire          rst_b_in,
    input  wire          ce_in,
    input  wire          cond_in,
    input  wire [TW-1:0] limit_in,
    output wire          done_out
);
    reg [TW-1:0] count_r;

    always @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            count_r <= {TW{1'b0}};
        else if (ce_in)
        begin
            if (!cond_in)
                count_r <= {TW{1'b0}};
            else if (count_r < limit_in)
                count_r <= count_r + {{(TW-1){1'b0}}, 1'b1};
        end
    end

    assign done_out = cond_in && (count_r >= limit_in);
endmodule // hold_qualifier

// file: verif/host_port_model.sv
/* host model: drives the register port and the speed pin.
   tasks are entered 1 ns after a rising clock edge. */
`timescale 1ns/10ps
module host_port_model
(
    input  wire        clk_in,
    input  wire [15:0] rdata_in,
    output reg         wr_out,
    output reg         rd_out,
    output reg  [7:0]  addr_out,
    output reg  [15:0] wdata_out,
    output reg         pin_out
);
    reg [15:0] q;
    initial {wr_out, rd_out, addr_out, wdata_out, pin_out} = 27'h1;
    // one strobe edge, read data taken there, then idle lines toggle
    task xfer(input w, input [7:0] a, input [15:0] d);
    begin
        {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
        @(posedge clk_in) #1;
        q = rdata_in;
        {wr_out, rd_out, addr_out, wdata_out} = {2'h0, ~a, ~d};
        @(posedge clk_in) #1;
    end
    endtask
    task set_pin(input v);
    begin
        pin_out = v;
    end
    endtask
    task sleep_seq;
    begin
        set_pin(1'b0);
        xfer(1'b1, 8'h30, 16'h8100);
        xfer(1'b1, 8'h30, 16'h8000);
    end
    endtask
endmodule // host_port_model

// file: verif/motor_fault_and_power_mode_ctrl_sva.sv
/* port checker for the motor fault and power-mode controller.
   idle while ce_in is low; async inputs act three edges later. */
`timescale 1ns/10ps
module motor_fault_sva
(
    input wire        sys_clk_in,
    input wire        rst_b_in,
    input wire        ce_in,
    input wire        temp_over_sdn_in,
    input wire        temp_warn_in,
    input wire        vcc_below_fall_in,
    input wire        oc_detect_in,
    input wire [5:0]  lock_detect_in,
    input wire [8:0]  clamp_limit_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_addr_in,
    input wire [15:0] reg_rdata_out,
    input wire [8:0]  output_duty_peak_out,
    input wire        drive_en_out,
    input wire        outputs_hiz_out,
    input wire        buck_en_out,
    input wire        serial_en_out,
    input wire [1:0]  power_state_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in || !ce_in);
    wire rd_stat = reg_rd_in && reg_addr_in == 8'h00 && power_state_out != 2'h2;
    property p_tsd; temp_over_sdn_in [*4] |=> !drive_en_out; endproperty
    a_tsd: assert property (p_tsd) else $error("tsd drive");
    property p_otf; temp_over_sdn_in [*4] ##0 rd_stat |=> reg_rdata_out[15];
    endproperty
    a_otf: assert property (p_otf) else $error("ot flag");
    property p_wrn; temp_warn_in [*4] ##0 rd_stat |=> reg_rdata_out[14];
    endproperty
    a_wrn: assert property (p_wrn) else $error("warn flag");
    property p_ocf; rd_stat && $past(oc_detect_in, 2) &&
        $past(oc_detect_in, 3) |=> reg_rdata_out[11]; endproperty
    a_ocf: assert property (p_ocf) else $error("oc flag");
    property p_hiz; oc_detect_in [*2] |-> ##[1:3] outputs_hiz_out; endproperty
    a_hiz: assert property (p_hiz) else $error("oc hiz");
    property p_uv; $rose(vcc_below_fall_in) |=> ##3 !drive_en_out; endproperty
    a_uv: assert property (p_uv) else $error("uvlo drive");
    property p_lck; $rose(|lock_detect_in) ##1 (|lock_detect_in) [*3]
        |=> !drive_en_out; endproperty
    a_lck: assert property (p_lck) else $error("lock drive");
    property p_clp; output_duty_peak_out <= $past(clamp_limit_in); endproperty
    a_clp: assert property (p_clp) else $error("clamp");
    property p_slp; (power_state_out == 2'h2) [*2]
        |-> !(buck_en_out | serial_en_out | drive_en_out); endproperty
    a_slp: assert property (p_slp) else $error("sleep outs");
endmodule // motor_fault_sva
bind motor_fault_and_power_mode_ctrl motor_fault_sva chk_i (.*);

// file: verif/motor_fault_and_power_mode_ctrl_bench.sv
/* self-checking bench for the motor fault and power-mode controller.
   assumes the host model owns the register port and the speed pin. */
`timescale 1ns/10ps
`include "motor_fault_map.vh"
module motor_fault_and_power_mode_ctrl_bench;
    localparam LK = 30;
    reg         sys_clk_in = 1'b0, rst_b_in = 1'b0;
    reg         temp_over_sdn_in = 1'b0, temp_warn_in = 1'b0;
    reg         temp_below_rec_in = 1'b1, vcc_above_rise_in = 1'b1;
    reg         vcc_below_fall_in = 1'b0, oc_detect_in = 1'b0;
    reg         buck_uv_in = 1'b0, cp_uv_in = 1'b0, ldo_uv_in = 1'b0;
    reg         vcc_above_ov_in = 1'b0, vcc_below_ov_exit_in = 1'b1;
    reg  [5:0]  lock_detect_in = 6'h00;
    reg  [8:0]  speed_level_in = 9'h100, clamp_limit_in = 9'h1ff;
    reg         ce_in = 1'b1;
    reg  [7:0]  wave_a_in = 8'hff, wave_b_in = 8'h80, wave_c_in = 8'h00;
    wire [8:0]  phase_a_duty_out, phase_b_duty_out, phase_c_duty_out;
    wire        reg_wr_in, reg_rd_in, speed_pin_in, drive_en_out;
    wire        outputs_hiz_out, buck_en_out, serial_en_out;
    wire [7:0]  reg_addr_in;
    wire [15:0] reg_wdata_in, reg_rdata_out;
    wire [8:0]  output_duty_peak_out;
    wire [1:0]  power_state_out;
    integer     n_errors = 0, cmp_count = 0, i, k, w;
    always #5 sys_clk_in = ~sys_clk_in;
    host_port_model host (.clk_in(sys_clk_in), .rdata_in(reg_rdata_out),
        .wr_out(reg_wr_in), .rd_out(reg_rd_in), .addr_out(reg_addr_in),
        .wdata_out(reg_wdata_in), .pin_out(speed_pin_in));
    motor_fault_and_power_mode_ctrl #(.LOCK_OFF_CYC(LK), .WIN_W(6),
        .EN_SL_ANA_CYC(20), .EX_SL_ANA_CYC(20), .EN_SL_PWM_CYC(400),
        .EX_SL_PWM_CYC(20)) uut (.*);
    task summarize;
    begin
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task chk(input [15:0] g, input [15:0] e);
    begin
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task cyc(input integer n);
    begin
        repeat (n) @(posedge sys_clk_in);
        #1;
    end
    endtask
    task drv(input integer n, input e);
    begin
        cyc(n);
        chk(drive_en_out, e);
    end
    endtask
    task rdc(input [7:0] a, input [15:0] m, input [15:0] e);
    begin
        host.xfer(1'b0, a, 16'h0000);
        chk(host.q & m, e);
    end
    endtask
    // bounded wait for a power state
    task wst(input [1:0] s);
    begin
        w = 0;
        while (power_state_out !== s && w < 800)
        begin
            cyc(1);
            w = w + 1;
        end
        chk(power_state_out, s);
        if (power_state_out !== s)
            summarize;
    end
    endtask
    initial
    begin
        cyc(4);
        rst_b_in = 1'b1;
        host.xfer(1'b1, 8'h3c, 16'h0002);
        host.xfer(1'b1, 8'h30, 16'h0100);
        drv(4, 1'b1);
        chk(output_duty_peak_out, 16'h0100);
        chk(phase_a_duty_out, 16'h0100);
        chk(phase_b_duty_out, 16'h0080);
        chk(phase_c_duty_out, 16'h0000);
        clamp_limit_in = 9'h080;
        cyc(3);
        chk(output_duty_peak_out, 16'h0080);
        clamp_limit_in = 9'h1ff;
        ce_in = 1'b0;
        temp_over_sdn_in = 1'b1;
        temp_below_rec_in = 1'b0;
        drv(6, 1'b1);
        ce_in = 1'b1;
        drv(5, 1'b0);
        rdc(8'h00, 16'h8000, 16'h8000);
        temp_over_sdn_in = 1'b0;
        drv(5, 1'b0);
        temp_below_rec_in = 1'b1;
        drv(5, 1'b1);
        rdc(8'h00, 16'h8000, 16'h0000);
        temp_warn_in = 1'b1;
        cyc(4);
        rdc(8'h00, 16'hc000, 16'h4000);
        temp_warn_in = 1'b0;
        oc_detect_in = 1'b1;
        cyc(4);
        oc_detect_in = 1'b0;
        rdc(8'h00, 16'h0800, 16'h0800);
        cyc(2);
        host.xfer(1'b0, 8'h00, 16'h0000);
        rdc(8'h00, 16'h0800, 16'h0000);
        chk(outputs_hiz_out, 16'h0001);
        cyc(LK - 16);
        chk(outputs_hiz_out, 16'h0001);
        cyc(22);
        chk(outputs_hiz_out, 16'h0000);
        lock_detect_in = 6'h04;
        drv(4, 1'b0);
        rdc(8'h00, 16'h003f, 16'h0004);
        k = 0;
        repeat (3 * LK)
        begin
            cyc(1);
            if (drive_en_out === 1'b1)
                k = k + 1;
        end
        chk(k >= 2 && k <= 3, 16'h0001);
        lock_detect_in = 6'h00;
        drv(LK + 10, 1'b1);
        vcc_below_fall_in = 1'b1;
        vcc_above_rise_in = 1'b0;
        drv(5, 1'b0);
        vcc_below_fall_in = 1'b0;
        drv(5, 1'b0);
        vcc_above_rise_in = 1'b1;
        drv(5, 1'b1);
        for (i = 0; i < 3; i = i + 1)
        begin
            {ldo_uv_in, cp_uv_in, buck_uv_in} = 3'h1 << i;
            drv(5, 1'b0);
            {ldo_uv_in, cp_uv_in, buck_uv_in} = 3'h0;
            drv(5, 1'b1);
        end
        vcc_above_ov_in = 1'b1;
        vcc_below_ov_exit_in = 1'b0;
        drv(5, 1'b0);
        vcc_above_ov_in = 1'b0;
        drv(5, 1'b0);
        vcc_below_ov_exit_in = 1'b1;
        drv(5, 1'b1);
        host.sleep_seq;
        wst(2'h2);
        chk({buck_en_out, serial_en_out, drive_en_out}, 16'h0000);
        rdc(8'h3c, 16'hffff, 16'h0000);
        host.set_pin(1'b1);
        wst(2'h0);
        rdc(8'h30, 16'hffff, 16'h0000);
        for (i = 1; i < 4; i = i + 1)
        begin
            host.xfer(1'b1, 8'h3c, {12'h000, i[1:0], 2'h1});
            repeat (4)
            begin
                host.set_pin(1'b1);
                cyc(4);
                host.set_pin(1'b0);
                cyc(60);
            end
            chk(output_duty_peak_out, i == 1 ? `MIN_DUTY_1 :
                i == 2 ? `MIN_DUTY_2 : `MIN_DUTY_3);
        end
        wst(2'h2);
        host.set_pin(1'b1);
        wst(2'h0);
        host.xfer(1'b1, 8'h3c, 16'h0000);
        speed_level_in = 9'h005;
        wst(2'h2);
        speed_level_in = 9'h030;
        cyc(60);
        chk(power_state_out, 16'h0002);
        speed_level_in = 9'h050;
        wst(2'h0);
        cyc(4);
        chk(output_duty_peak_out, 16'h0050);
        summarize;
    end
endmodule // motor_fault_and_power_mode_ctrl_bench
